// [rtl/drf_defs.svh]
// constants for the reference mask, failure and frequency report block
// Operation
// - A 16-bit read/write check mask register sits at offset 006A hex, resets to zero and holds one nibble per reference, reference 3 on top.
// - A set multi-period lower-limit mask bit (top bit of a nibble) makes that reference's multi-period lower check pass.
// - A set multi-period upper-limit mask bit (second bit of a nibble) makes that reference's multi-period upper check pass.
// - A set single-period lower-limit mask bit (third bit of a nibble) makes that reference's single-period lower check pass.
// - A set single-period upper-limit mask bit (lowest bit of a nibble) makes that reference's single-period upper check pass.
// - Reference 3's detected frequency reads as a 3-bit code in bits 11 to 9, coded 8 kHz up to 19.44 MHz, 111 reserved.
// - A read-only failure flag register at offset 0069 hex shows one flag per reference and check, and a masked check never fails.
`ifndef DRF_DEFS_SVH
`define DRF_DEFS_SVH

// register indices; byte address is four times the index
`define DRF_IDX_FAIL      8'h69
`define DRF_IDX_MASK      8'h6A
`define DRF_IDX_FREQ      8'h6B
`define DRF_IDX_IRQ_STAT  8'h70
`define DRF_IDX_IRQ_MASK  8'h71
`define DRF_IDX_LSB       2

// register layout
`define DRF_REG_W         16
`define DRF_MASK_RST      16'h0000
`define DRF_IRQ_RST       16'h0000
`define DRF_NREF          4
`define DRF_NIB_W         4
`define DRF_CODE_W        3
`define DRF_BUS_W         32
`define DRF_SEL_W         4

// clock and nominal reference periods in picoseconds
`define DRF_CLK_PS        5000
`define DRF_PER_8K_PS     125000000
`define DRF_PER_1544_PS   647668
`define DRF_PER_2048_PS   488281
`define DRF_PER_4096_PS   244141
`define DRF_PER_8192_PS   122070
`define DRF_PER_16384_PS  61035
`define DRF_PER_1944_PS   51440

// loss of reference: no edge for this long
`define DRF_LOSS_TIME_NS  250000
`define DRF_LOSS_CYCLES   ((`DRF_LOSS_TIME_NS * 1000) / `DRF_CLK_PS)

// averaging window is two to this power periods
`define DRF_AVG_LOG2      3
// single-period tolerance is nominal shifted right by this
`define DRF_SGL_TOL_SH    2
// multi-period tolerance is the nominal window sum shifted right by this
`define DRF_MUL_TOL_SH    5

`endif

// [rtl/drf_pkg.sv]
// types shared by the reference mask, failure and frequency report block
package drf_pkg;

	// detected frequency code of one reference
	typedef enum logic [2:0] {
		DRF_F_8K    = 3'h0,
		DRF_F_1544  = 3'h1,
		DRF_F_2048  = 3'h2,
		DRF_F_4096  = 3'h3,
		DRF_F_8192  = 3'h4,
		DRF_F_16384 = 3'h5,
		DRF_F_1944  = 3'h6,
		DRF_F_RSVD  = 3'h7
	} drf_freq_t;

	// one nibble of checks, in register bit order
	typedef struct packed {
		logic multi_lower;
		logic multi_upper;
		logic single_lower;
		logic single_upper;
	} drf_chk_t;

	// classic wishbone request as seen by the slave
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [31:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} drf_wb_req_t;

	// per-reference meter state, one-hot
	typedef enum logic [1:0] {
		DRF_ST_IDLE    = 2'b01,
		DRF_ST_MEASURE = 2'b10
	} drf_state_t;

endpackage : drf_pkg

// [rtl/drf_sync.sv]
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module drf_sync (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// asynchronous level
	input  wire logic async_in,
	// filtered level and its rising edge
	output logic      level_out,
	output logic      rise_out
);
	import drf_pkg::*;

	logic       s1_q;
	logic       s2_q;
	logic       s3_q;
	logic       lvl_q;
	logic       rise_q;
	logic       primed_q;
	logic [2:0] fill_q;

	// shift chain; stage one feeds stage two only
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// stages hold real pin samples once three edges have passed since reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			fill_q <= 3'h0;
		end else begin
			fill_q <= {fill_q[1:0], 1'b1};
		end
	end

	// a change counts once stages two and three agree; the first agreement
	// only loads the level, so a pin already high at reset gives no false edge
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			lvl_q    <= 1'b0;
			rise_q   <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			rise_q <= primed_q && (s2_q == s3_q) && s3_q && !lvl_q;
			if (fill_q[2] && (s2_q == s3_q)) begin
				lvl_q    <= s3_q;
				primed_q <= 1'b1;
			end
		end
	end

	assign level_out = lvl_q;
	assign rise_out  = rise_q;

endmodule : drf_sync

// [rtl/drf_irq.sv]
// sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_irq (
	// clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        sys_rst_in,
	// events, one pulse per rising failure flag
	input  wire drf_pkg::drf_chk_t [3:0]     event_in,
	// software writes: clear pattern and new mask
	input  wire logic [`DRF_REG_W-1:0]       clear_in,
	input  wire logic                        mask_we_in,
	input  wire logic [`DRF_REG_W-1:0]       mask_in,
	// state and interrupt
	output logic [`DRF_REG_W-1:0]            status_out,
	output logic [`DRF_REG_W-1:0]            mask_out,
	output logic                             irq_out
);
	import drf_pkg::*;

	logic [`DRF_REG_W-1:0] stat_q;
	logic [`DRF_REG_W-1:0] mask_q;

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			stat_q <= `DRF_IRQ_RST;
		end else begin
			stat_q <= (stat_q & ~clear_in) | event_in;
		end
	end

	// enable mask
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mask_q <= `DRF_IRQ_RST;
		end else if (mask_we_in) begin
			mask_q <= mask_in;
		end
	end

	assign status_out = stat_q;
	assign mask_out   = mask_q;
	assign irq_out    = |(stat_q & mask_q);

endmodule : drf_irq

// [rtl/drf_top.sv]
// reference monitor: period checks with mask, failure flags, frequency report, wishbone slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_top #(
	parameter int unsigned ADDR_W      = 12,
	parameter int unsigned CNT_W       = 16,
	parameter int unsigned AVG_LOG2    = `DRF_AVG_LOG2,
	parameter int unsigned LOSS_CYCLES = `DRF_LOSS_CYCLES
) (
	// clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     sys_rst_in,
	// reference clock pins, asynchronous
	input  wire logic [`DRF_NREF-1:0]     timing_input_in,
	// wishbone slave
	input  wire logic                     wb_cyc_in,
	input  wire logic                     wb_stb_in,
	input  wire logic                     wb_we_in,
	input  wire logic [ADDR_W-1:0]        wb_adr_in,
	input  wire logic [`DRF_SEL_W-1:0]    wb_sel_in,
	input  wire logic [`DRF_BUS_W-1:0]    wb_dat_in,
	output logic [`DRF_BUS_W-1:0]         wb_dat_out,
	output logic                          wb_ack_out,
	// interrupt
	output logic                          irq_out
);
	import drf_pkg::*;

	// the period counter stops at LOSS_LAST, so LOSS_CYCLES must not exceed 2**CNT_W
	localparam int unsigned SUM_W = CNT_W + AVG_LOG2;
	localparam int unsigned IDX_W = ADDR_W - `DRF_IDX_LSB;
	localparam logic [CNT_W-1:0] LOSS_LAST = CNT_W'(LOSS_CYCLES - 1);
	localparam logic [AVG_LOG2-1:0] WIN_LAST = {AVG_LOG2{1'b1}};

	// nominal period of a frequency code in clock cycles
	function automatic logic [CNT_W-1:0] nominal(input drf_freq_t code);
		int unsigned ps;
		ps = `DRF_PER_8K_PS;
		unique case (code)
			DRF_F_8K:    ps = `DRF_PER_8K_PS;
			DRF_F_1544:  ps = `DRF_PER_1544_PS;
			DRF_F_2048:  ps = `DRF_PER_2048_PS;
			DRF_F_4096:  ps = `DRF_PER_4096_PS;
			DRF_F_8192:  ps = `DRF_PER_8192_PS;
			DRF_F_16384: ps = `DRF_PER_16384_PS;
			DRF_F_1944:  ps = `DRF_PER_1944_PS;
			DRF_F_RSVD:  ps = `DRF_PER_8K_PS;
		endcase
		return CNT_W'(ps / `DRF_CLK_PS);
	endfunction : nominal

	// midpoint between two codes' nominal periods
	function automatic logic [CNT_W-1:0] midpoint(input drf_freq_t a, input drf_freq_t b);
		logic [CNT_W:0] s;
		s = {1'b0, nominal(a)} + {1'b0, nominal(b)};
		return s[CNT_W:1];
	endfunction : midpoint

	// nearest nominal frequency for an average period
	function automatic drf_freq_t classify(input logic [CNT_W-1:0] avg);
		drf_freq_t c;
		if (avg < midpoint(DRF_F_1944, DRF_F_16384)) begin
			c = DRF_F_1944;
		end else if (avg < midpoint(DRF_F_16384, DRF_F_8192)) begin
			c = DRF_F_16384;
		end else if (avg < midpoint(DRF_F_8192, DRF_F_4096)) begin
			c = DRF_F_8192;
		end else if (avg < midpoint(DRF_F_4096, DRF_F_2048)) begin
			c = DRF_F_4096;
		end else if (avg < midpoint(DRF_F_2048, DRF_F_1544)) begin
			c = DRF_F_2048;
		end else if (avg < midpoint(DRF_F_1544, DRF_F_8K)) begin
			c = DRF_F_1544;
		end else begin
			c = DRF_F_8K;
		end
		return c;
	endfunction : classify

	// word-index match for a register
	function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] idx);
		return adr[ADDR_W-1:`DRF_IDX_LSB] == IDX_W'(idx);
	endfunction : reg_hit

	// expand byte selects over the 16-bit register
	function automatic logic [`DRF_REG_W-1:0] lane_mask(input logic [`DRF_SEL_W-1:0] sel);
		return {{8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	// bus request carried as one struct
	drf_wb_req_t req;
	assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in,
	               adr: 32'(wb_adr_in), sel: wb_sel_in, dat: wb_dat_in};

	// registers and per-reference results
	logic [`DRF_REG_W-1:0]         mask_q;
	drf_chk_t [`DRF_NREF-1:0]      raw_fail;
	drf_chk_t [`DRF_NREF-1:0]      fail_now;
	drf_chk_t [`DRF_NREF-1:0]      fail_prev_q;
	drf_chk_t [`DRF_NREF-1:0]      fail_rise;
	drf_chk_t [`DRF_NREF-1:0]      mask_chk;
	drf_freq_t [`DRF_NREF-1:0]     code;
	logic [`DRF_NREF-1:0]          rise;

	assign mask_chk = mask_q;

	// per-reference measurement: synchroniser, period counter, window sum, checks
	// a period is the cycle count between recognised rising edges, held against
	// the nominal of the code in force; each window of 2**AVG_LOG2 periods is summed,
	// checked and reclassified; no edge for LOSS_CYCLES flags both upper checks
	for (genvar g = 0; g < `DRF_NREF; g++) begin : g_ref
		drf_state_t          st_q;
		logic [CNT_W-1:0]    per_cnt_q;
		logic [SUM_W-1:0]    sum_q;
		logic [AVG_LOG2-1:0] n_q;
		drf_freq_t           code_q;
		drf_chk_t            fail_q;
		logic [CNT_W-1:0]    per;
		logic [CNT_W-1:0]    nom;
		logic [SUM_W-1:0]    sum_new;
		logic [SUM_W-1:0]    win_nom;

		drf_sync u_sync (
			.clk_in     (clk_in),
			.sys_rst_in (sys_rst_in),
			.async_in   (timing_input_in[g]),
			.level_out  (),
			.rise_out   (rise[g])
		);

		// length of the period that just ended, and the window totals
		assign per     = per_cnt_q + CNT_W'(1);
		assign nom     = nominal(code_q);
		assign sum_new = sum_q + SUM_W'(per);
		assign win_nom = SUM_W'(nom) << AVG_LOG2;

		// period counting, loss detection and state
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				st_q      <= DRF_ST_IDLE;
				per_cnt_q <= '0;
			end else begin
				unique case (st_q)
					DRF_ST_IDLE: begin
						per_cnt_q <= '0;
						if (rise[g]) begin
							st_q <= DRF_ST_MEASURE;
						end
					end
					DRF_ST_MEASURE: begin
						if (rise[g]) begin
							per_cnt_q <= '0;
						end else if (per_cnt_q == LOSS_LAST) begin
							st_q      <= DRF_ST_IDLE; // reference lost
							per_cnt_q <= '0;
						end else begin
							per_cnt_q <= per;
						end
					end
				endcase
			end
		end

		// averaging window and detected frequency
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				sum_q  <= '0;
				n_q    <= '0;
				code_q <= DRF_F_8K;
			end else if (st_q == DRF_ST_IDLE) begin
				sum_q <= '0;
				n_q   <= '0;
			end else if (rise[g]) begin
				n_q <= n_q + AVG_LOG2'(1);
				if (n_q == WIN_LAST) begin
					sum_q  <= '0;
					code_q <= classify(CNT_W'(sum_new >> AVG_LOG2));
				end else begin
					sum_q <= sum_new;
				end
			end
		end

		// raw period checks; lower means too short, upper too long or lost
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				fail_q <= '0;
			end else if (st_q == DRF_ST_MEASURE) begin
				if (rise[g]) begin
					fail_q.single_lower <= per < (nom - (nom >> `DRF_SGL_TOL_SH));
					fail_q.single_upper <= per > (nom + (nom >> `DRF_SGL_TOL_SH));
					if (n_q == WIN_LAST) begin
						fail_q.multi_lower <= sum_new < (win_nom - (win_nom >> `DRF_MUL_TOL_SH));
						fail_q.multi_upper <= sum_new > (win_nom + (win_nom >> `DRF_MUL_TOL_SH));
					end
				end else if (per_cnt_q == LOSS_LAST) begin
					fail_q.single_upper <= 1'b1;
					fail_q.multi_upper  <= 1'b1;
				end
			end
		end

		assign raw_fail[g] = fail_q;
		assign code[g]     = code_q;
	end

	// a set mask bit forces its check to pass
	always_comb begin
		for (int r = 0; r < `DRF_NREF; r++) begin
			fail_now[r].multi_lower  = raw_fail[r].multi_lower  & ~mask_chk[r].multi_lower;
			fail_now[r].multi_upper  = raw_fail[r].multi_upper  & ~mask_chk[r].multi_upper;
			fail_now[r].single_lower = raw_fail[r].single_lower & ~mask_chk[r].single_lower;
			fail_now[r].single_upper = raw_fail[r].single_upper & ~mask_chk[r].single_upper;
		end
	end

	// rising failure flags become interrupt events
	// clearing a mask bit over a standing failure is an event as well
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			fail_prev_q <= '0;
		end else begin
			fail_prev_q <= fail_now;
		end
	end

	assign fail_rise = fail_now & ~fail_prev_q;

	// register map, word index is the byte address over four
	//   failure flags     read only, raw checks with the check mask applied
	//   check mask        read/write
	//   frequency report  read only, four codes, top nibble zero
	//   interrupt status  write one to clear, a set wins over the clear
	//   interrupt mask    read/write
	//   anything else     acknowledged, reads zero, writes dropped
	//   byte lanes: sel[0] bits 7:0, sel[1] bits 15:8, upper lanes ignored
	// bus decode
	logic                  ack_q;
	logic [`DRF_BUS_W-1:0] dat_q;
	logic                  req_on;
	logic                  wr_commit;
	logic [`DRF_REG_W-1:0] lanes;
	logic [`DRF_REG_W-1:0] wr_val;
	logic [`DRF_REG_W-1:0] irq_stat;
	logic [`DRF_REG_W-1:0] irq_mask;
	logic [`DRF_REG_W-1:0] irq_clear;
	logic [`DRF_REG_W-1:0] freq_word;
	logic                  hit_fail;
	logic                  hit_mask;
	logic                  hit_freq;
	logic                  hit_ist;
	logic                  hit_imsk;
	logic                  irq_raw;
	logic                  irq_q;

	assign req_on    = req.cyc && req.stb;
	assign wr_commit = req_on && req.we && ack_q;
	assign lanes     = lane_mask(req.sel);
	assign wr_val    = req.dat[`DRF_REG_W-1:0];

	// one select per register, shared by the read mux and the write strobes
	assign hit_fail = reg_hit(req.adr[ADDR_W-1:0], `DRF_IDX_FAIL);
	assign hit_mask = reg_hit(req.adr[ADDR_W-1:0], `DRF_IDX_MASK);
	assign hit_freq = reg_hit(req.adr[ADDR_W-1:0], `DRF_IDX_FREQ);
	assign hit_ist  = reg_hit(req.adr[ADDR_W-1:0], `DRF_IDX_IRQ_STAT);
	assign hit_imsk = reg_hit(req.adr[ADDR_W-1:0], `DRF_IDX_IRQ_MASK);

	// frequency report word, top nibble reads zero
	assign freq_word = {4'h0, code[3], code[2], code[1], code[0]};

	// ack one cycle after the request is taken, dropped the cycle after
	// a request still held after ack would be taken again, so masters idle a cycle
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req_on && !ack_q;
		end
	end

	// read data captured when the request is taken; unmapped reads zero
	// the word holds until the next request is taken, so a slow master still sees it
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			dat_q <= '0;
		end else if (req_on && !ack_q) begin
			dat_q <= '0;
			if (hit_fail) begin
				dat_q <= `DRF_BUS_W'(fail_now);
			end else if (hit_mask) begin
				dat_q <= `DRF_BUS_W'(mask_q);
			end else if (hit_freq) begin
				dat_q <= `DRF_BUS_W'(freq_word);
			end else if (hit_ist) begin
				dat_q <= `DRF_BUS_W'(irq_stat);
			end else if (hit_imsk) begin
				dat_q <= `DRF_BUS_W'(irq_mask);
			end
		end
	end

	// check mask register, written at the acknowledging edge
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mask_q <= `DRF_MASK_RST;
		end else if (wr_commit && hit_mask) begin
			mask_q <= (mask_q & ~lanes) | (wr_val & lanes);
		end
	end

	// interrupt status clear pattern
	assign irq_clear = (wr_commit && hit_ist)
	                   ? (wr_val & lanes) : '0;

	// interrupt status and mask
	drf_irq u_irq (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.event_in   (fail_rise),
		.clear_in   (irq_clear),
		.mask_we_in (wr_commit && hit_imsk),
		.mask_in    ((irq_mask & ~lanes) | (wr_val & lanes)),
		.status_out (irq_stat),
		.mask_out   (irq_mask),
		.irq_out    (irq_raw)
	);

	// interrupt level from a flip-flop, one cycle behind status and mask
	// keeps the pin free of decode glitches
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_raw;
		end
	end

	assign wb_ack_out = ack_q;
	assign wb_dat_out = dat_q;
	assign irq_out    = irq_q;

endmodule : drf_top

// [tb/drf_ref_model.sv]
// four free-running reference clocks that stop low when disabled
`timescale 1ns/1ps
module drf_ref_model #(
	parameter int P0 = 10,
	parameter int P1 = 12,
	parameter int P2 = 24,
	parameter int P3 = 7
) (
	// clock and per-reference enable
	input  wire logic       clk_in,
	input  wire logic [3:0] run_in,
	// reference pins
	output logic [3:0]      timing_input_out
);
	localparam int PER [4] = '{P0, P1, P2, P3};
	int cnt_q [4];
	// a stopped reference stands low, as a lost clock does
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 4; i++) begin
			if (!run_in[i]) begin
				cnt_q[i] <= 0;
				timing_input_out[i] <= 1'b0;
			end else begin
				cnt_q[i] <= (cnt_q[i] == PER[i] - 1) ? 0 : cnt_q[i] + 1;
				timing_input_out[i] <= (cnt_q[i] < (PER[i] + 1) / 2);
			end
		end
	end
endmodule : drf_ref_model

// [tb/drf_top_assertions.sv]
// bus and register checks on the ports of the reference monitor
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_top_assertions #(
	parameter int unsigned ADDR_W = 12
) (
	// clock and reset
	input wire logic              clk_in,
	input wire logic              sys_rst_in,
	// wishbone slave
	input wire logic              wb_cyc_in,
	input wire logic              wb_stb_in,
	input wire logic              wb_we_in,
	input wire logic [ADDR_W-1:0] wb_adr_in,
	input wire logic [3:0]        wb_sel_in,
	input wire logic [31:0]       wb_dat_in,
	input wire logic [31:0]       wb_dat_out,
	input wire logic              wb_ack_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	logic [ADDR_W-3:0] idx;
	logic              rd_ack;
	logic [15:0]       shadow_q;
	// decoded word index and read completion
	assign idx = wb_adr_in[ADDR_W-1:2];
	assign rd_ack = wb_ack_out && wb_cyc_in && wb_stb_in && !wb_we_in;
	// expected check mask, byte by byte
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			shadow_q <= 16'h0000;
		end else if (wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && idx == `DRF_IDX_MASK) begin
			if (wb_sel_in[0]) shadow_q[7:0] <= wb_dat_in[7:0];
			if (wb_sel_in[1]) shadow_q[15:8] <= wb_dat_in[15:8];
		end
	end
	a_ack_after_take: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing one cycle after request");
	a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without request");
	a_mask_readback: assert property (rd_ack && idx == `DRF_IDX_MASK |-> wb_dat_out[15:0] == shadow_q)
		else $error("check mask read differs from written value");
	a_upper_half_zero: assert property (rd_ack |-> wb_dat_out[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_freq_top_zero: assert property (rd_ack && idx == `DRF_IDX_FREQ |-> wb_dat_out[15:12] == 4'h0)
		else $error("frequency word top nibble not zero");
	a_freq_no_rsvd: assert property (rd_ack && idx == `DRF_IDX_FREQ |-> wb_dat_out[11:9] != 3'h7 &&
		wb_dat_out[8:6] != 3'h7 && wb_dat_out[5:3] != 3'h7 && wb_dat_out[2:0] != 3'h7)
		else $error("reserved frequency code reported");
	a_masked_no_fail: assert property (rd_ack && idx == `DRF_IDX_FAIL |-> (wb_dat_out[15:0] & shadow_q) == 16'h0000)
		else $error("masked check reported as failed");
endmodule : drf_top_assertions
bind drf_top drf_top_assertions #(.ADDR_W(ADDR_W)) u_drf_top_assertions (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));

// [tb/tb.sv]
// register-level testbench of the reference monitor
`timescale 1ns/1ps
`define TB_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
	localparam logic [11:0] A_FAIL = 12'h1A4, A_MASK = 12'h1A8, A_FREQ = 12'h1AC;
	localparam logic [11:0] A_IST = 12'h1C0, A_IMSK = 12'h1C4;
	logic        clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat, d;
	logic        ack, irq;
	logic [3:0]  run_q = 4'hF;
	logic [3:0]  ref_pins;
	int          num_errors = 0;
	int          cmp_count = 0;
	logic [15:0] mtab [6] = '{16'h0000, 16'h8000, 16'h2000, 16'h0004, 16'h0001, 16'hFFFF};
	logic [31:0] ftab [6] = '{32'h0000_A005, 32'h0000_2005, 32'h0000_8005, 32'h0000_A001, 32'h0000_A004, 32'h0000_0000};
	// 200 MHz clock
	always #2.5 clk_in = ~clk_in;
	// four references: 19.44, 16.384, 8.192 MHz and one running too fast
	drf_ref_model #(.P0(10), .P1(12), .P2(24), .P3(7)) u_drf_ref_model (.clk_in(clk_in), .run_in(run_q),
		.timing_input_out(ref_pins));
	// loss time shortened, still longer than any reference period
	drf_top #(.LOSS_CYCLES(200)) u_drf_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .timing_input_in(ref_pins),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq));
	// one classic cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] v, input logic [3:0] s,
		output logic [31:0] r);
		int n;
		@(posedge clk_in);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {16'h0000, v};
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [3:0] s);
		logic [31:0] r;
		xfer(1'b1, a, v, s, r);
	endtask : wr
	task automatic end_test(input string name);
		$display("test %s done, errors so far %0d", name, num_errors);
	endtask : end_test
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test
	// hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
	// test sequence
	initial begin
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		xfer(1'b0, A_MASK, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_0000)
		xfer(1'b0, A_FREQ, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_0000)
		xfer(1'b0, A_FAIL, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_0000)
		xfer(1'b0, A_IMSK, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_0000)
		end_test("reset");
		wr(A_MASK, 16'h1234, 4'hF);
		wr(A_MASK, 16'hFFFF, 4'h1);
		xfer(1'b0, A_MASK, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_12FF)
		wr(A_FREQ, 16'hFFFF, 4'hF);
		xfer(1'b0, 12'h004, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_0000)
		end_test("mask access");
		// many eight-period windows on the slowest reference
		repeat (1500) @(posedge clk_in);
		wr(A_MASK, 16'h0000, 4'h3);
		xfer(1'b0, A_FREQ, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_0D2E)
		end_test("frequency");
		// reference 0 lost: both upper checks fail; reference 3 fast: both lower checks fail
		@(posedge clk_in);
		run_q <= 4'hE;
		repeat (600) @(posedge clk_in);
		for (int i = 0; i < 6; i++) begin
			wr(A_MASK, mtab[i], 4'h3);
			xfer(1'b0, A_FAIL, 16'h0000, 4'h0, d); `TB_CHK(d, ftab[i])
		end
		end_test("failure masking");
		// unmasking raises the failure bits, which land in the sticky status
		wr(A_IST, 16'hFFFF, 4'h3);
		wr(A_MASK, 16'h0000, 4'h3);
		repeat (4) @(posedge clk_in);
		xfer(1'b0, A_IST, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_A005)
		`TB_CHK(irq, 1'b0)
		wr(A_IMSK, 16'h0001, 4'h3);
		repeat (2) @(posedge clk_in);
		`TB_CHK(irq, 1'b1)
		wr(A_IST, 16'h0001, 4'h3);
		repeat (2) @(posedge clk_in);
		`TB_CHK(irq, 1'b0)
		xfer(1'b0, A_IST, 16'h0000, 4'h0, d); `TB_CHK(d, 32'h0000_A004)
		end_test("interrupt");
		stop_test();
	end
endmodule : tb
